/* cplm_pkg.sv */
// Constants, types and register map of the channel peak and limit monitor
package cplm_pkg;
    localparam int NCH = 7;
    localparam int VW = 16;
    localparam logic [2:0] LAST_CH = 3'h6;
    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_MASK = 12'h008;
    localparam logic [11:0] OFS_STATE = 12'h00c;
    localparam logic [11:0] OFS_SAVED_CTRL = 12'h010;
    localparam logic [11:0] OFS_LIMIT = 12'h040;
    localparam logic [11:0] OFS_DBAND = 12'h060;
    localparam logic [11:0] OFS_MAX = 12'h080;
    localparam logic [11:0] OFS_MIN = 12'h0a0;
    localparam logic [11:0] OFS_RATE = 12'h0c0;
    localparam logic [11:0] OFS_SAVED_LIMIT = 12'h100;
    localparam logic [11:0] OFS_SAVED_DBAND = 12'h120;
    // Control fields; all reset to zero: latched, buzzer off, normally open, channels on
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_BUZZ_BIT = 1;
    localparam int CTRL_NC_LSB = 8;
    localparam int CTRL_OFF_LSB = 16;
    localparam logic [31:0] CTRL_MASK = 32'h007f7f03;
    localparam int ST_SAVE_BIT = 7;
    // Timing
    localparam longint CLK_HZ = 25000000;
    localparam longint BANNER_MS = 1000;
    localparam longint PEAK_TIMEOUT_MS = 5000;
    localparam longint MINUTE_MS = 60000;
    localparam int BANNER_CYC = int'(BANNER_MS * CLK_HZ / 1000);
    localparam int PEAK_TIMEOUT_CYC = int'(PEAK_TIMEOUT_MS * CLK_HZ / 1000);
    localparam int MINUTE_CYC = int'(MINUTE_MS * CLK_HZ / 1000);
    typedef enum logic [3:0] {
        DSP_NORMAL = 4'h0, DSP_CHAN = 4'h1, DSP_HI_BAN = 4'h2, DSP_HI_VAL = 4'h3,
        DSP_LO_BAN = 4'h4, DSP_LO_VAL = 4'h5, DSP_OFF_BAN = 4'h6, DSP_RST_BAN = 4'h7,
        DSP_RATE_BAN = 4'h8, DSP_RATE_VAL = 4'h9
    } cplm_dsp_t;
    typedef struct packed {cplm_dsp_t mode; logic [2:0] chan; logic [VW-1:0] value;} cplm_disp_t;
    typedef struct packed {logic valid; logic [2:0] chan; logic [VW-1:0] value;} cplm_sample_t;
    typedef struct packed {logic chsel; logic peak; logic reset; logic rate;} cplm_keys_t;
    typedef struct packed {logic psel; logic penable; logic pwrite; logic [11:0] paddr; logic [31:0] pwdata;} cplm_apb_req_t;
    typedef struct packed {logic [31:0] prdata; logic pready; logic pslverr;} cplm_apb_rsp_t;
endpackage

/* cplm_monitor.sv */
// Channel peak, rate and limit monitor with APB register access
module cplm_monitor #(
    parameter int BANNER_CYCLES = cplm_pkg::BANNER_CYC,
    parameter int PEAK_TIMEOUT_CYCLES = cplm_pkg::PEAK_TIMEOUT_CYC,
    parameter int MINUTE_CYCLES = cplm_pkg::MINUTE_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire cplm_pkg::cplm_apb_req_t i_apb,
    output cplm_pkg::cplm_apb_rsp_t o_apb,
    input wire cplm_pkg::cplm_sample_t i_sample,
    input wire cplm_pkg::cplm_keys_t i_keys,
    output cplm_pkg::cplm_disp_t o_display,
    output logic [cplm_pkg::NCH-1:0] o_relay_coil,
    output logic [cplm_pkg::NCH-1:0] o_relay_closed,
    output logic [cplm_pkg::NCH-1:0] o_oc_out,
    output logic [cplm_pkg::NCH-1:0] o_led,
    output logic o_buzzer,
    output logic o_nv_save,
    output logic o_irq
);
    typedef logic [cplm_pkg::NCH-1:0][cplm_pkg::VW-1:0] cplm_vals_t;
    typedef struct packed {
        cplm_pkg::cplm_keys_t k1, k2, k3;
        cplm_pkg::cplm_apb_rsp_t apb;
        logic [31:0] ctrl, sv_ctrl;
        cplm_vals_t limit, dband, sv_limit, sv_dband, pv, pmax, pmin, base, rate;
        logic [cplm_pkg::NCH-1:0] seen, active;
        logic [7:0] status, mask;
        logic [2:0] sel;
        cplm_pkg::cplm_dsp_t dst;
        logic rst_hi;
        logic [31:0] tmr, min_tmr;
        cplm_pkg::cplm_disp_t disp;
        logic [cplm_pkg::NCH-1:0] closed;
        logic buzz, nv_save, irq;
    } cplm_state_t;

    cplm_state_t state_reg, state_next;
    cplm_pkg::cplm_keys_t press;
    logic [cplm_pkg::NCH-1:0] off_bits, nc_bits;
    logic auto_rel, in_hi, in_lo, tmo;

    assign off_bits = state_reg.ctrl[cplm_pkg::CTRL_OFF_LSB +: cplm_pkg::NCH];
    assign nc_bits = state_reg.ctrl[cplm_pkg::CTRL_NC_LSB +: cplm_pkg::NCH];
    assign auto_rel = state_reg.ctrl[cplm_pkg::CTRL_AUTO_BIT];
    // Edge detect reads only the second and third stages, never the first
    assign press = state_reg.k2 & ~state_reg.k3;
    assign in_hi = (state_reg.dst == cplm_pkg::DSP_HI_BAN) || (state_reg.dst == cplm_pkg::DSP_HI_VAL);
    assign in_lo = (state_reg.dst == cplm_pkg::DSP_LO_BAN) || (state_reg.dst == cplm_pkg::DSP_LO_VAL);
    assign tmo = (state_reg.tmr == 32'h0);

    // Next-state logic for the whole block
    always_comb
    begin
        logic [11:0] a;
        logic [2:0] ix;
        logic idx_ok, acc, setup;
        logic [31:0] rd;
        logic rd_ok;
        logic [cplm_pkg::NCH-1:0] rise;
        logic signed [cplm_pkg::VW:0] sum;
        a = i_apb.paddr;
        ix = a[4:2];
        idx_ok = (ix <= cplm_pkg::LAST_CH);
        acc = i_apb.psel && i_apb.penable && state_reg.apb.pready;
        setup = i_apb.psel && !i_apb.penable;
        rd = 32'h0;
        rd_ok = 1'b1;
        rise = '0;
        sum = '0;
        state_next = state_reg;
        state_next.k1 = i_keys;
        state_next.k2 = state_reg.k1;
        state_next.k3 = state_reg.k2;
        state_next.nv_save = 1'b0;

        // New reading: store and track extremes, off channels ignored
        if (i_sample.valid && i_sample.chan <= cplm_pkg::LAST_CH && !off_bits[i_sample.chan])
        begin
            state_next.pv[i_sample.chan] = i_sample.value;
            state_next.seen[i_sample.chan] = 1'b1;
            if (!state_reg.seen[i_sample.chan] || $signed(i_sample.value) > $signed(state_reg.pmax[i_sample.chan]))
                state_next.pmax[i_sample.chan] = i_sample.value;
            if (!state_reg.seen[i_sample.chan] || $signed(i_sample.value) < $signed(state_reg.pmin[i_sample.chan]))
                state_next.pmin[i_sample.chan] = i_sample.value;
        end

        // Rate per minute: difference against the reading a minute ago
        if (state_reg.min_tmr >= 32'(MINUTE_CYCLES - 1))
        begin
            state_next.min_tmr = 32'h0;
            for (int i = 0; i < cplm_pkg::NCH; i++)
            begin
                state_next.rate[i] = state_reg.pv[i] - state_reg.base[i];
                state_next.base[i] = state_reg.pv[i];
            end
        end
        else
            state_next.min_tmr = state_reg.min_tmr + 32'h1;

        // Limit compare with deadband on release, per channel
        for (int i = 0; i < cplm_pkg::NCH; i++)
        begin
            sum = 17'($signed(state_reg.pv[i])) + 17'($signed(state_reg.dband[i]));
            if (off_bits[i])
                state_next.active[i] = 1'b0;
            else if ($signed(state_reg.pv[i]) >= $signed(state_reg.limit[i]))
                state_next.active[i] = 1'b1;
            else if (auto_rel && sum < 17'($signed(state_reg.limit[i])))
                state_next.active[i] = 1'b0;
        end

        // Key handling; channel key has priority over the others
        if (press.chsel)
        begin
            state_next.sel = (state_reg.sel == cplm_pkg::LAST_CH) ? 3'h0 : state_reg.sel + 3'h1;
            state_next.dst = cplm_pkg::DSP_CHAN;
            state_next.tmr = 32'(PEAK_TIMEOUT_CYCLES);
        end
        else if (press.peak)
        begin
            state_next.tmr = 32'(BANNER_CYCLES);
            if (off_bits[state_reg.sel])
            begin
                state_next.dst = cplm_pkg::DSP_OFF_BAN;
                state_next.tmr = 32'(PEAK_TIMEOUT_CYCLES);
            end
            else if (in_hi)
                state_next.dst = cplm_pkg::DSP_LO_BAN;
            else
                state_next.dst = cplm_pkg::DSP_HI_BAN;
        end
        else if (press.rate)
        begin
            state_next.dst = cplm_pkg::DSP_RATE_BAN;
            state_next.tmr = 32'(BANNER_CYCLES);
        end
        else if (press.reset && state_reg.k2.peak && (in_hi || in_lo))
        begin
            state_next.dst = cplm_pkg::DSP_RST_BAN;
            state_next.rst_hi = in_hi;
            state_next.tmr = 32'(BANNER_CYCLES);
        end
        else if (press.reset && state_reg.k2.chsel)
            state_next.active[state_reg.sel] = 1'b0;
        else if (press.reset)
        begin
            // Commit working setup to the storage image
            state_next.sv_ctrl = state_reg.ctrl;
            state_next.sv_limit = state_reg.limit;
            state_next.sv_dband = state_reg.dband;
            state_next.nv_save = 1'b1;
        end
        else if ((in_hi || in_lo) && state_reg.k2.peak && !tmo && state_reg.dst != cplm_pkg::DSP_HI_BAN
                 && state_reg.dst != cplm_pkg::DSP_LO_BAN)
            state_next.tmr = state_reg.tmr; // Held key keeps the peak shown so reset can follow
        else if (!tmo)
            state_next.tmr = state_reg.tmr - 32'h1;
        else
        begin
            state_next.tmr = 32'(PEAK_TIMEOUT_CYCLES);
            case (state_reg.dst)
                cplm_pkg::DSP_HI_BAN: state_next.dst = cplm_pkg::DSP_HI_VAL;
                cplm_pkg::DSP_LO_BAN: state_next.dst = cplm_pkg::DSP_LO_VAL;
                cplm_pkg::DSP_RATE_BAN: state_next.dst = cplm_pkg::DSP_RATE_VAL;
                cplm_pkg::DSP_RST_BAN:
                begin
                    // Banner first, then the present value becomes the new peak
                    if (state_reg.rst_hi)
                    begin
                        state_next.pmax[state_reg.sel] = state_reg.pv[state_reg.sel];
                        state_next.dst = cplm_pkg::DSP_HI_VAL;
                    end
                    else
                    begin
                        state_next.pmin[state_reg.sel] = state_reg.pv[state_reg.sel];
                        state_next.dst = cplm_pkg::DSP_LO_VAL;
                    end
                end
                default: state_next.dst = cplm_pkg::DSP_NORMAL;
            endcase
        end

        // APB read mux, sampled in the setup phase
        case (a)
            cplm_pkg::OFS_CTRL: rd = state_reg.ctrl;
            cplm_pkg::OFS_STATUS: rd = {24'h0, state_reg.status};
            cplm_pkg::OFS_MASK: rd = {24'h0, state_reg.mask};
            cplm_pkg::OFS_STATE: rd = {17'h0, state_reg.sel, state_reg.dst, 1'b0, state_reg.active};
            cplm_pkg::OFS_SAVED_CTRL: rd = state_reg.sv_ctrl;
            default:
            begin
                rd_ok = idx_ok;
                case ({a[11:5], 5'h0})
                    cplm_pkg::OFS_LIMIT: rd = 32'($signed(state_reg.limit[ix]));
                    cplm_pkg::OFS_DBAND: rd = {16'h0, state_reg.dband[ix]};
                    cplm_pkg::OFS_MAX: rd = 32'($signed(state_reg.pmax[ix]));
                    cplm_pkg::OFS_MIN: rd = 32'($signed(state_reg.pmin[ix]));
                    cplm_pkg::OFS_RATE: rd = 32'($signed(state_reg.rate[ix]));
                    cplm_pkg::OFS_SAVED_LIMIT: rd = 32'($signed(state_reg.sv_limit[ix]));
                    cplm_pkg::OFS_SAVED_DBAND: rd = {16'h0, state_reg.sv_dband[ix]};
                    default: rd_ok = 1'b0;
                endcase
                if (!rd_ok)
                    rd = 32'h0;
            end
        endcase
        state_next.apb.pready = setup;
        if (setup)
        begin
            state_next.apb.prdata = rd;
            state_next.apb.pslverr = !rd_ok;
        end

        // Writes and read-clear take effect at the access edge only
        if (acc && i_apb.pwrite && !state_reg.apb.pslverr)
        begin
            if (a == cplm_pkg::OFS_CTRL)
                state_next.ctrl = i_apb.pwdata & cplm_pkg::CTRL_MASK;
            else if (a == cplm_pkg::OFS_MASK)
                state_next.mask = i_apb.pwdata[7:0];
            else if ({a[11:5], 5'h0} == cplm_pkg::OFS_LIMIT)
                state_next.limit[ix] = i_apb.pwdata[15:0];
            else if ({a[11:5], 5'h0} == cplm_pkg::OFS_DBAND)
                state_next.dband[ix] = i_apb.pwdata[15:0];
        end
        // Only bits the reader actually saw are cleared; new events win
        if (acc && !i_apb.pwrite && a == cplm_pkg::OFS_STATUS)
            state_next.status = state_reg.status & ~state_reg.apb.prdata[7:0];
        rise = state_next.active & ~state_reg.active;
        state_next.status = state_next.status | {state_next.nv_save, rise};

        // Registered outputs
        state_next.irq = |(state_next.status & state_next.mask);
        state_next.closed = state_next.active ^ nc_bits;
        state_next.buzz = state_reg.ctrl[cplm_pkg::CTRL_BUZZ_BIT] && (|state_next.active);
        state_next.disp.mode = state_next.dst;
        state_next.disp.chan = state_next.sel;
        case (state_next.dst)
            cplm_pkg::DSP_NORMAL: state_next.disp.value = state_next.pv[state_next.sel];
            cplm_pkg::DSP_CHAN: state_next.disp.value = {13'h0, state_next.sel} + 16'h1;
            cplm_pkg::DSP_HI_VAL: state_next.disp.value = state_next.pmax[state_next.sel];
            cplm_pkg::DSP_LO_VAL: state_next.disp.value = state_next.pmin[state_next.sel];
            cplm_pkg::DSP_RATE_VAL: state_next.disp.value = state_next.rate[state_next.sel];
            default: state_next.disp.value = 16'h0;
        endcase
    end

    // State register
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign o_apb = state_reg.apb;
    assign o_display = state_reg.disp;
    assign o_relay_coil = state_reg.active;
    assign o_relay_closed = state_reg.closed;
    assign o_oc_out = state_reg.active;
    assign o_led = state_reg.active;
    assign o_buzzer = state_reg.buzz;
    assign o_nv_save = state_reg.nv_save;
    assign o_irq = state_reg.irq;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_max_tracks: assert property (i_sample.valid && i_sample.chan == 3'h0 && !off_bits[0] && state_reg.seen[0]
        && $signed(i_sample.value) > $signed(state_reg.pmax[0]) |=> state_reg.pmax[0] == $past(i_sample.value))
        else $error("maximum not updated");
    a_min_tracks: assert property (i_sample.valid && i_sample.chan == 3'h0 && !off_bits[0] && state_reg.seen[0]
        && $signed(i_sample.value) < $signed(state_reg.pmin[0]) |=> state_reg.pmin[0] == $past(i_sample.value))
        else $error("minimum not updated");
    a_chan_advance: assert property (press.chsel |=> o_display.mode == cplm_pkg::DSP_CHAN
        && state_reg.sel == (($past(state_reg.sel) == cplm_pkg::LAST_CH) ? 3'h0 : $past(state_reg.sel) + 3'h1))
        else $error("channel select did not advance");
    a_peak_second: assert property (press.peak && !press.chsel && in_hi && !off_bits[state_reg.sel]
        |=> state_reg.dst == cplm_pkg::DSP_LO_BAN)
        else $error("second peak press did not select minimum");
    a_off_banner: assert property (press.peak && !press.chsel && off_bits[state_reg.sel]
        |=> o_display.mode == cplm_pkg::DSP_OFF_BAN)
        else $error("off channel showed a peak");
    a_reset_high: assert property (state_reg.dst == cplm_pkg::DSP_RST_BAN && state_reg.rst_hi && tmo
        && press == '0 |=> state_reg.pmax[$past(state_reg.sel)] == $past(state_reg.pv[state_reg.sel]))
        else $error("high peak not reset to present value");
    a_limit_reach: assert property (!off_bits[0] && $signed(state_reg.pv[0]) >= $signed(state_reg.limit[0])
        && !(press.reset && state_reg.k2.chsel) |=> o_relay_coil[0]) // Manual clear may drop it for one cycle
        else $error("limit reached but output idle");
    a_deadband_hold: assert property (!off_bits[0] && state_reg.active[0] && !press.reset
        && 17'($signed(state_reg.pv[0])) + 17'($signed(state_reg.dband[0])) >= 17'($signed(state_reg.limit[0]))
        |=> o_relay_coil[0])
        else $error("released inside deadband");
    a_contact_sense: assert property (o_relay_closed == (o_relay_coil ^ $past(nc_bits)))
        else $error("contact sense wrong");
    a_led_oc_same: assert property (o_led == o_relay_coil && o_oc_out == o_relay_coil)
        else $error("led or open collector differs from relay");
    a_buzzer_any: assert property (##1 o_buzzer == ($past(state_reg.ctrl[cplm_pkg::CTRL_BUZZ_BIT]) && |o_relay_coil))
        else $error("buzzer wrong");
    a_save_on_reset: assert property (o_nv_save |-> $past(press.reset) && state_reg.sv_ctrl == $past(state_reg.ctrl))
        else $error("save without reset key");

    c_peak_low: cover property (state_reg.dst == cplm_pkg::DSP_LO_VAL);
    c_reset_peak: cover property (state_reg.dst == cplm_pkg::DSP_RST_BAN);
    c_limit_irq: cover property (o_irq && |o_relay_coil);
    c_rate_view: cover property (state_reg.dst == cplm_pkg::DSP_RATE_VAL);
endmodule

/* cplm_panel_model.sv */
// Front-panel keypad model that drives the four key levels
module cplm_panel_model (
    input wire logic i_ref_clk,
    output cplm_pkg::cplm_keys_t o_keys
);
    timeunit 1ns;
    timeprecision 1ns;
    // Bits 3..0: channel select, peak view, reset, rate
    logic [3:0] key_reg = 4'h0;
    assign o_keys = cplm_pkg::cplm_keys_t'(key_reg);
    // Level is held three edges so the two-stage synchroniser sees it
    task automatic put(input int b, input logic v);
        @(posedge i_ref_clk);
        key_reg[b] <= v;
        repeat (3) @(posedge i_ref_clk);
    endtask
endmodule

/* channel_peak_limit_monitor_tb.sv */
// Self-checking bench for the channel peak and limit monitor
module channel_peak_limit_monitor_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BAN = 4;
    localparam int TMO = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    cplm_pkg::cplm_apb_req_t req = '0;
    cplm_pkg::cplm_apb_rsp_t rsp;
    cplm_pkg::cplm_sample_t smp = '0;
    cplm_pkg::cplm_keys_t keys;
    cplm_pkg::cplm_disp_t disp;
    logic [6:0] coil, closed, oc, led;
    logic buzz, save, irq, re;
    logic saw_save = 1'b0;
    logic [31:0] rv;
    int n_fail = 0;
    int check_count = 0;
    cplm_monitor #(.BANNER_CYCLES(BAN), .PEAK_TIMEOUT_CYCLES(TMO), .MINUTE_CYCLES(50)) DUT (
        .i_ref_clk(clk), .i_rst(rst), .i_apb(req), .o_apb(rsp), .i_sample(smp), .i_keys(keys),
        .o_display(disp), .o_relay_coil(coil), .o_relay_closed(closed), .o_oc_out(oc), .o_led(led),
        .o_buzzer(buzz), .o_nv_save(save), .o_irq(irq));
    cplm_panel_model u_panel (.i_ref_clk(clk), .o_keys(keys));
    initial forever #20 clk = ~clk;
    // The save strobe is one cycle wide, so keep a sticky copy
    always @(posedge clk) if (save === 1'b1) saw_save <= 1'b1;
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        // No local limit: only the watchdog ends a hung transfer
        while (rsp.pready !== 1'b1)
            @(posedge clk);
        rv = rsp.prdata;
        re = rsp.pslverr;
        req <= '0;
        chk("apb_ready", 32'(rsp.pready), 32'h1);
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rv, exp);
    endtask
    task automatic smp_put(input logic [2:0] c, input logic [15:0] v);
        @(posedge clk);
        smp <= '{valid: 1'b1, chan: c, value: v};
        @(posedge clk);
        smp.valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // Bounded wait for a display mode
    task automatic wm(input cplm_pkg::cplm_dsp_t m, input int lim);
        int n;
        n = 0;
        @(posedge clk);
        while (disp.mode !== m && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        chk("display_mode", 32'(disp.mode), 32'(m));
    endtask
    // Span is far above the few hundred cycles the sequence needs
    initial
    begin
        repeat (8000) @(posedge clk);
        n_fail++;
        complete_run();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdc("ctrl_reset", cplm_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, cplm_pkg::OFS_CTRL, 32'h00000103);
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b1, cplm_pkg::OFS_LIMIT + 12'(4 * i), 32'h64);
            apb(1'b1, cplm_pkg::OFS_DBAND + 12'(4 * i), 32'ha);
        end
        apb(1'b0, cplm_pkg::OFS_STATUS, 32'h0);
        chk("contact_idle_nc", 32'(closed), 32'h1);
        smp_put(3'h0, 16'h0032);
        smp_put(3'h0, 16'h0078);
        chk("coil", 32'(coil), 32'h1);
        chk("led", 32'(led), 32'h1);
        chk("oc", 32'(oc), 32'h1);
        chk("contact_nc", 32'(closed), 32'h0);
        chk("buzzer", 32'(buzz), 32'h1);
        chk("irq_masked", 32'(irq), 32'h0);
        apb(1'b1, cplm_pkg::OFS_MASK, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq", 32'(irq), 32'h1);
        rdc("status", cplm_pkg::OFS_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq_clear", 32'(irq), 32'h0);
        smp_put(3'h0, 16'h005f);
        chk("coil_deadband", 32'(coil), 32'h1);
        smp_put(3'h0, 16'h0055);
        chk("coil_release", 32'(coil), 32'h0);
        smp_put(3'h0, 16'h001e);
        rdc("max0", cplm_pkg::OFS_MAX, 32'h78);
        rdc("min0", cplm_pkg::OFS_MIN, 32'h1e);
        apb(1'b1, cplm_pkg::OFS_CTRL, 32'h0);
        smp_put(3'h1, 16'h0078);
        smp_put(3'h1, 16'h000a);
        chk("coil_latched", 32'(coil), 32'h2);
        chk("buzzer_off", 32'(buzz), 32'h0);
        u_panel.put(3, 1'b1);
        wm(cplm_pkg::DSP_CHAN, 10);
        chk("chan_shown", 32'(disp.value), 32'h2);
        u_panel.put(1, 1'b1);
        u_panel.put(1, 1'b0);
        u_panel.put(3, 1'b0);
        chk("coil_cleared", 32'(coil), 32'h0);
        u_panel.put(2, 1'b1);
        wm(cplm_pkg::DSP_HI_BAN, 10);
        u_panel.put(2, 1'b0);
        wm(cplm_pkg::DSP_HI_VAL, 10);
        chk("high_peak", 32'(disp.value), 32'h78);
        u_panel.put(2, 1'b1);
        wm(cplm_pkg::DSP_LO_BAN, 10);
        u_panel.put(2, 1'b0);
        wm(cplm_pkg::DSP_LO_VAL, 10);
        chk("low_peak", 32'(disp.value), 32'ha);
        wm(cplm_pkg::DSP_NORMAL, TMO + 10);
        u_panel.put(2, 1'b1);
        wm(cplm_pkg::DSP_HI_VAL, 20);
        smp_put(3'h1, 16'h0037);
        u_panel.put(1, 1'b1);
        wm(cplm_pkg::DSP_RST_BAN, 10);
        u_panel.put(1, 1'b0);
        wm(cplm_pkg::DSP_HI_VAL, 10);
        chk("max_reset", 32'(disp.value), 32'h37);
        u_panel.put(2, 1'b0);
        u_panel.put(2, 1'b1);
        wm(cplm_pkg::DSP_LO_VAL, 20);
        smp_put(3'h1, 16'h0042);
        u_panel.put(1, 1'b1);
        wm(cplm_pkg::DSP_RST_BAN, 10);
        u_panel.put(1, 1'b0);
        wm(cplm_pkg::DSP_LO_VAL, 10);
        chk("min_reset", 32'(disp.value), 32'h42);
        u_panel.put(2, 1'b0);
        wm(cplm_pkg::DSP_NORMAL, TMO + 10);
        apb(1'b1, cplm_pkg::OFS_CTRL, 32'h00020000);
        u_panel.put(2, 1'b1);
        wm(cplm_pkg::DSP_OFF_BAN, 10);
        chk("off_chan", 32'(disp.chan), 32'h1);
        u_panel.put(2, 1'b0);
        wm(cplm_pkg::DSP_NORMAL, TMO + 10);
        u_panel.put(0, 1'b1);
        wm(cplm_pkg::DSP_RATE_BAN, 10);
        chk("rate_chan", 32'(disp.chan), 32'h1);
        u_panel.put(0, 1'b0);
        wm(cplm_pkg::DSP_RATE_VAL, 10);
        // Step of 0x10 shows at the next minute tick and stands a full minute
        smp_put(3'h0, 16'h002e);
        rv = 32'h0;
        for (int i = 0; i < 30 && rv !== 32'h10; i++)
            apb(1'b0, cplm_pkg::OFS_RATE, 32'h0);
        chk("rate0", rv, 32'h10);
        rdc("saved_before", cplm_pkg::OFS_SAVED_LIMIT, 32'h0);
        u_panel.put(1, 1'b1);
        u_panel.put(1, 1'b0);
        chk("save_strobe", 32'(saw_save), 32'h1);
        rdc("saved_limit", cplm_pkg::OFS_SAVED_LIMIT, 32'h64);
        rdc("saved_ctrl", cplm_pkg::OFS_SAVED_CTRL, 32'h00020000);
        rdc("unmapped", 12'h200, 32'h0);
        chk("unmapped_err", 32'(re), 32'h1);
        rdc("limit6", cplm_pkg::OFS_LIMIT + 12'h018, 32'h64);
        rdc("limit7", cplm_pkg::OFS_LIMIT + 12'h01c, 32'h0);
        chk("limit7_err", 32'(re), 32'h1);
        complete_run();
    end
endmodule
